// >>> hdl/trim_swap_regs.sv
/*
  Trim and swap-delay register bank behind an AXI4-Lite slave.
  Assumes fuse values are stable when fuse_valid pulses after reset, and
  that the converter clock rate arrives as a one-cycle enable.
*/
`timescale 1ns/1ps
`default_nettype none
module trim_swap_regs (
  // Clock and reset
  input  wire logic                ref_clk,
  input  wire logic                rst_n,
  // Factory fuse storage
  input  wire logic                fuse_valid,
  input  wire trim_regs_pkg::trim_set_t fuse_trims,
  // Swap sequencer
  input  wire logic                conv_clk_en,
  input  wire logic                swap_start,
  // Analog trim outputs
  output trim_regs_pkg::trim_set_t trims,
  output logic                     overlap_active,
  output logic                     cal_enable,
  // AXI4-Lite write address
  input  wire logic                s_axi_awvalid,
  output logic                     s_axi_awready,
  input  wire logic [11:0]         s_axi_awaddr,
  // AXI4-Lite write data
  input  wire logic                s_axi_wvalid,
  output logic                     s_axi_wready,
  input  wire logic [31:0]         s_axi_wdata,
  input  wire logic [3:0]          s_axi_wstrb,
  // AXI4-Lite write response
  output logic                     s_axi_bvalid,
  input  wire logic                s_axi_bready,
  output logic [1:0]               s_axi_bresp,
  // AXI4-Lite read address
  input  wire logic                s_axi_arvalid,
  output logic                     s_axi_arready,
  input  wire logic [11:0]         s_axi_araddr,
  // AXI4-Lite read data
  output logic                     s_axi_rvalid,
  input  wire logic                s_axi_rready,
  output logic [31:0]              s_axi_rdata,
  output logic [1:0]               s_axi_rresp
);

  // ==========================================================
  // Reset release
  // ==========================================================
  logic rst_meta_q;
  logic rst_sync_n;

  always_ff @(posedge ref_clk or negedge rst_n) begin
    if (!rst_n) begin
      rst_meta_q <= 1'b0;
      rst_sync_n <= 1'b0;
    end else begin
      rst_meta_q <= 1'b1;
      rst_sync_n <= rst_meta_q;
    end
  end

  // ==========================================================
  // Write channel capture
  // ==========================================================
  logic        aw_held_q;
  logic        w_held_q;
  logic [9:0]  aw_idx_q;
  logic        aw_ok_q;
  logic [7:0]  wdata_q;
  logic        wstrb0_q;
  logic        wr_fire;

  assign s_axi_awready = !aw_held_q && !s_axi_bvalid;
  assign s_axi_wready  = !w_held_q && !s_axi_bvalid;

  always_ff @(posedge ref_clk or negedge rst_sync_n) begin
    if (!rst_sync_n) begin
      aw_held_q <= 1'b0;
    end else if (s_axi_awvalid && s_axi_awready) begin
      aw_held_q <= 1'b1;
    end else if (wr_fire) begin
      aw_held_q <= 1'b0;
    end
  end

  always_ff @(posedge ref_clk or negedge rst_sync_n) begin
    if (!rst_sync_n) begin
      aw_idx_q <= '0;
      aw_ok_q  <= 1'b0;
    end else if (s_axi_awvalid && s_axi_awready) begin
      aw_idx_q <= s_axi_awaddr[11:2];
      aw_ok_q  <= (s_axi_awaddr[1:0] == 2'h0);
    end
  end

  always_ff @(posedge ref_clk or negedge rst_sync_n) begin
    if (!rst_sync_n) begin
      w_held_q <= 1'b0;
    end else if (s_axi_wvalid && s_axi_wready) begin
      w_held_q <= 1'b1;
    end else if (wr_fire) begin
      w_held_q <= 1'b0;
    end
  end

  always_ff @(posedge ref_clk or negedge rst_sync_n) begin
    if (!rst_sync_n) begin
      wdata_q  <= '0;
      wstrb0_q <= 1'b0;
    end else if (s_axi_wvalid && s_axi_wready) begin
      wdata_q  <= s_axi_wdata[7:0];
      wstrb0_q <= s_axi_wstrb[0];
    end
  end

  assign wr_fire = aw_held_q && w_held_q;

  // ==========================================================
  // Address decode
  // ==========================================================
  function automatic logic idx_mapped(input logic [9:0] idx);
    idx_mapped = (idx == trim_regs_pkg::IDX_CORE_GAIN_TRIM)
              || (idx == trim_regs_pkg::IDX_BANDGAP_TRIM)
              || (idx == trim_regs_pkg::IDX_TERM_TRIM_CH0)
              || (idx == trim_regs_pkg::IDX_TERM_TRIM_CH1)
              || (idx == trim_regs_pkg::IDX_TERM_TRIM_CH2)
              || (idx == trim_regs_pkg::IDX_TERM_TRIM_CH3)
              || (idx == trim_regs_pkg::IDX_SWAP_OVERLAP)
              || (idx == trim_regs_pkg::IDX_SWAP_CTRL);
  endfunction

  logic wr_ok;
  logic wr_en;

  assign wr_ok = aw_ok_q && idx_mapped(aw_idx_q);
  assign wr_en = wr_fire && wr_ok && wstrb0_q;

  // ==========================================================
  // Write select, one strobe per register
  // ==========================================================
  localparam logic [trim_regs_pkg::NUM_CH-1:0][9:0] TERM_IDX = {
    trim_regs_pkg::IDX_TERM_TRIM_CH3,
    trim_regs_pkg::IDX_TERM_TRIM_CH2,
    trim_regs_pkg::IDX_TERM_TRIM_CH1,
    trim_regs_pkg::IDX_TERM_TRIM_CH0
  };

  logic                                  fuse_done_q;
  logic                                  fuse_load;
  logic                                  sel_gain;
  logic                                  sel_bandgap;
  logic [trim_regs_pkg::NUM_CH-1:0]      sel_term;
  logic                                  sel_delay;
  logic                                  sel_ctrl;

  // Factory load wins over any early software write to a trim or overlap delay register
  assign fuse_load   = fuse_valid && !fuse_done_q;
  assign sel_gain    = wr_en && (aw_idx_q == trim_regs_pkg::IDX_CORE_GAIN_TRIM);
  assign sel_bandgap = wr_en && (aw_idx_q == trim_regs_pkg::IDX_BANDGAP_TRIM);
  assign sel_delay   = wr_en && (aw_idx_q == trim_regs_pkg::IDX_SWAP_OVERLAP);
  assign sel_ctrl    = wr_en && (aw_idx_q == trim_regs_pkg::IDX_SWAP_CTRL);

  always_ff @(posedge ref_clk or negedge rst_sync_n) begin
    if (!rst_sync_n) begin
      fuse_done_q <= 1'b0;
    end else if (fuse_load) begin
      fuse_done_q <= 1'b1;
    end
  end

  // ==========================================================
  // Trim storage
  // ==========================================================
  logic [7:0]                            gain_q;
  logic [7:0]                            bandgap_q;
  logic [trim_regs_pkg::NUM_CH-1:0][7:0] term_q;
  logic [7:0]                            delay_q;
  logic                                  cal_en_q;
  logic [4:0]                            delay_in_use;

  // Gain trim, one value for all cores
  always_ff @(posedge ref_clk or negedge rst_sync_n) begin
    if (!rst_sync_n) begin
      gain_q <= '0;
    end else if (fuse_load) begin
      gain_q <= fuse_trims.core_gain;
    end else if (sel_gain) begin
      gain_q <= wdata_q;
    end
  end

  always_ff @(posedge ref_clk or negedge rst_sync_n) begin
    if (!rst_sync_n) begin
      bandgap_q <= '0;
    end else if (fuse_load) begin
      bandgap_q <= {4'h0, fuse_trims.bandgap};
    end else if (sel_bandgap) begin
      bandgap_q <= wdata_q & trim_regs_pkg::BANDGAP_MASK;
    end
  end

  // Each channel trims only its own input
  for (genvar c = 0; c < trim_regs_pkg::NUM_CH; c++) begin : g_term
    assign sel_term[c] = wr_en && (aw_idx_q == TERM_IDX[c]);

    always_ff @(posedge ref_clk or negedge rst_sync_n) begin
      if (!rst_sync_n) begin
        term_q[c] <= '0;
      end else if (fuse_load) begin
        term_q[c] <= fuse_trims.term[c];
      end else if (sel_term[c]) begin
        term_q[c] <= wdata_q;
      end
    end
  end

  always_ff @(posedge ref_clk or negedge rst_sync_n) begin
    if (!rst_sync_n) begin
      delay_q <= trim_regs_pkg::DELAY_RESET;
    end else if (fuse_load) begin
      delay_q <= {3'h0, fuse_trims.overlap_delay};
    end else if (sel_delay) begin
      delay_q <= wdata_q & trim_regs_pkg::DELAY_MASK;
    end
  end

  always_ff @(posedge ref_clk or negedge rst_sync_n) begin
    if (!rst_sync_n) begin
      cal_en_q <= 1'b0;
    end else if (sel_ctrl) begin
      cal_en_q <= wdata_q[trim_regs_pkg::CTRL_CAL_EN_BIT];
    end
  end

  assign cal_enable = cal_en_q;

  // ==========================================================
  // Outputs to the analog trims
  // ==========================================================
  always_ff @(posedge ref_clk or negedge rst_sync_n) begin
    if (!rst_sync_n) begin
      trims <= '0;
    end else begin
      trims.core_gain     <= gain_q;
      trims.bandgap       <= bandgap_q[trim_regs_pkg::BANDGAP_W-1:0];
      trims.term          <= term_q;
      trims.overlap_delay <= delay_in_use;
    end
  end

  // ==========================================================
  // Swap overlap timer
  // ==========================================================
  swap_overlap_timer #(
    .DELAY_W (trim_regs_pkg::DELAY_W),
    .CNT_W   (trim_regs_pkg::OVL_CNT_W)
  ) u_overlap (
    .clk            (ref_clk),
    .rst_n          (rst_sync_n),
    .conv_clk_en    (conv_clk_en),
    .swap_start     (swap_start && cal_en_q),
    .delay          (delay_q[trim_regs_pkg::DELAY_W-1:0]),
    .overlap_active (overlap_active),
    .delay_in_use   (delay_in_use)
  );

  // ==========================================================
  // Write response
  // ==========================================================
  always_ff @(posedge ref_clk or negedge rst_sync_n) begin
    if (!rst_sync_n) begin
      s_axi_bvalid <= 1'b0;
    end else if (wr_fire) begin
      s_axi_bvalid <= 1'b1;
    end else if (s_axi_bready) begin
      s_axi_bvalid <= 1'b0;
    end
  end

  // Answer code fixed when the pair is complete
  always_ff @(posedge ref_clk or negedge rst_sync_n) begin
    if (!rst_sync_n) begin
      s_axi_bresp <= trim_regs_pkg::RESP_OKAY;
    end else if (wr_fire) begin
      s_axi_bresp <= wr_ok ? trim_regs_pkg::RESP_OKAY : trim_regs_pkg::RESP_SLVERR;
    end
  end

  // ==========================================================
  // Read path
  // ==========================================================
  logic [7:0] rd_byte;
  logic [7:0] ctrl_word;
  logic [9:0] ar_idx;
  logic       rd_ok;

  assign s_axi_arready = !s_axi_rvalid;
  assign ar_idx        = s_axi_araddr[11:2];
  assign rd_ok         = (s_axi_araddr[1:0] == 2'h0) && idx_mapped(ar_idx);

  // Status bits beside the calibration enable
  always_comb begin
    ctrl_word = 8'h00;
    ctrl_word[trim_regs_pkg::CTRL_CAL_EN_BIT]    = cal_en_q;
    ctrl_word[trim_regs_pkg::CTRL_BUSY_BIT]      = overlap_active;
    ctrl_word[trim_regs_pkg::CTRL_FUSE_DONE_BIT] = fuse_done_q;
  end

  always_comb begin
    rd_byte = 8'h00;
    unique case (ar_idx)
      trim_regs_pkg::IDX_CORE_GAIN_TRIM: rd_byte = gain_q;
      trim_regs_pkg::IDX_BANDGAP_TRIM:   rd_byte = bandgap_q;
      trim_regs_pkg::IDX_TERM_TRIM_CH0:  rd_byte = term_q[0];
      trim_regs_pkg::IDX_TERM_TRIM_CH1:  rd_byte = term_q[1];
      trim_regs_pkg::IDX_TERM_TRIM_CH2:  rd_byte = term_q[2];
      trim_regs_pkg::IDX_TERM_TRIM_CH3:  rd_byte = term_q[3];
      trim_regs_pkg::IDX_SWAP_OVERLAP:   rd_byte = delay_q;
      trim_regs_pkg::IDX_SWAP_CTRL:      rd_byte = ctrl_word;
      default: rd_byte = 8'h00;
    endcase
  end

  // Handshake state
  always_ff @(posedge ref_clk or negedge rst_sync_n) begin
    if (!rst_sync_n) begin
      s_axi_rvalid <= 1'b0;
    end else if (s_axi_arvalid && s_axi_arready) begin
      s_axi_rvalid <= 1'b1;
    end else if (s_axi_rready) begin
      s_axi_rvalid <= 1'b0;
    end
  end

  // Payload captured with the address
  always_ff @(posedge ref_clk or negedge rst_sync_n) begin
    if (!rst_sync_n) begin
      s_axi_rdata <= '0;
      s_axi_rresp <= trim_regs_pkg::RESP_OKAY;
    end else if (s_axi_arvalid && s_axi_arready) begin
      s_axi_rdata <= {24'h000000, rd_byte};
      s_axi_rresp <= rd_ok ? trim_regs_pkg::RESP_OKAY : trim_regs_pkg::RESP_SLVERR;
    end
  end

endmodule
`default_nettype wire

// >>> hdl/trim_regs_pkg.sv
/*
  Constants, field layouts and carrier types for the trim and swap-delay
  register bank. Assumes an AXI4-Lite master with 32-bit data and a fuse
  reader that presents factory values and a load-done strobe.
*/
package trim_regs_pkg;

  // ==========================================================
  // Register indices, byte address is four times the index
  // ==========================================================
  localparam logic [9:0] IDX_CORE_GAIN_TRIM   = 10'h07a;
  localparam logic [9:0] IDX_BANDGAP_TRIM     = 10'h07c;
  localparam logic [9:0] IDX_TERM_TRIM_CH0    = 10'h07e;
  localparam logic [9:0] IDX_TERM_TRIM_CH1    = 10'h07f;
  localparam logic [9:0] IDX_TERM_TRIM_CH2    = 10'h080;
  localparam logic [9:0] IDX_TERM_TRIM_CH3    = 10'h081;
  localparam logic [9:0] IDX_SWAP_OVERLAP     = 10'h09a;
  localparam logic [9:0] IDX_SWAP_CTRL        = 10'h0f0;

  // ==========================================================
  // Field layout and reset values
  // ==========================================================
  localparam int         BANDGAP_W            = 4;
  localparam int         DELAY_W              = 5;
  localparam int         NUM_CH               = 4;
  localparam logic [7:0] DELAY_RESET          = 8'h08;
  localparam logic [7:0] BANDGAP_MASK         = 8'h0f;
  localparam logic [7:0] DELAY_MASK           = 8'h1f;
  localparam int         CTRL_CAL_EN_BIT      = 0;
  localparam int         CTRL_BUSY_BIT        = 1;
  localparam int         CTRL_FUSE_DONE_BIT   = 2;

  // ==========================================================
  // Swap overlap timing, in converter clock cycles
  // ==========================================================
  localparam int         OVERLAP_BASE         = 4;
  localparam int         OVERLAP_SCALE        = 2;
  localparam int         OVL_CNT_W            = 7;

  // ==========================================================
  // AXI4-Lite answers
  // ==========================================================
  localparam logic [1:0] RESP_OKAY            = 2'h0;
  localparam logic [1:0] RESP_SLVERR          = 2'h2;

  typedef struct packed {
    logic [7:0]                 core_gain;
    logic [BANDGAP_W-1:0]       bandgap;
    logic [NUM_CH-1:0][7:0]     term;
    logic [DELAY_W-1:0]         overlap_delay;
  } trim_set_t;

endpackage

// >>> hdl/swap_overlap_timer.sv
/*
  Overlap timer for one background core swap. Counts converter clock
  enables. Assumes swap_start is a one-cycle pulse in the register clock.
*/
`timescale 1ns/1ps
`default_nettype none
module swap_overlap_timer #(
  parameter int DELAY_W = 5,
  parameter int CNT_W   = 7
) (
  // Clock and reset
  input  wire logic               clk,
  input  wire logic               rst_n,
  // Swap control
  input  wire logic               conv_clk_en,
  input  wire logic               swap_start,
  input  wire logic [DELAY_W-1:0] delay,
  // Status
  output logic                    overlap_active,
  output logic [DELAY_W-1:0]      delay_in_use
);

  logic [CNT_W-1:0] remain_q;

  // Capture delay at swap start only
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      delay_in_use <= '0;
    end else if (swap_start && !overlap_active) begin
      delay_in_use <= delay;
    end
  end

  // Count 4 + 2*delay converter cycles
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      remain_q <= '0;
    end else if (swap_start && !overlap_active) begin
      remain_q <= CNT_W'(trim_regs_pkg::OVERLAP_BASE)
                + CNT_W'(trim_regs_pkg::OVERLAP_SCALE * int'(delay));
    end else if (conv_clk_en && remain_q != '0) begin
      remain_q <= remain_q - CNT_W'(1);
    end
  end

  assign overlap_active = (remain_q != '0);

endmodule
`default_nettype wire

// >>> tb/trim_swap_regs_monitor.sv
/*
  Concurrent checks for the trim and swap-delay register bank.
  Assumes it is bound into trim_swap_regs and sees only its ports.
*/
`timescale 1ns/1ps
`default_nettype none
module trim_swap_regs_monitor (
  // Clock, reset and swap
  input wire logic                     ref_clk,
  input wire logic                     rst_n,
  input wire logic                     conv_clk_en,
  input wire logic                     swap_start,
  input wire logic                     overlap_active,
  input wire logic                     cal_enable,
  input wire trim_regs_pkg::trim_set_t trims,
  // Bus handshakes
  input wire logic                     s_axi_awvalid,
  input wire logic                     s_axi_awready,
  input wire logic                     s_axi_wvalid,
  input wire logic                     s_axi_wready,
  input wire logic                     s_axi_bvalid,
  input wire logic                     s_axi_bready,
  input wire logic                     s_axi_arvalid,
  input wire logic                     s_axi_arready,
  input wire logic                     s_axi_rvalid,
  input wire logic [31:0]              s_axi_rdata
);
  default clocking @(posedge ref_clk); endclocking
  default disable iff (!rst_n);

  logic [6:0] ovl_q;

  // Converter pulses seen in the current overlap
  always_ff @(posedge ref_clk or negedge rst_n) begin
    if (!rst_n) ovl_q <= 7'h00;
    else if (!overlap_active) ovl_q <= 7'h00;
    else if (conv_clk_en) ovl_q <= ovl_q + 7'h01;
  end

  sequence s_wr_pair;
    s_axi_awvalid && s_axi_awready && s_axi_wvalid && s_axi_wready;
  endsequence
  sequence s_swap_go;
    swap_start && cal_enable && !overlap_active;
  endsequence

  property p_wr_resp; s_wr_pair |-> ##[1:2] s_axi_bvalid; endproperty
  a_wr_resp: assert property (p_wr_resp) else $error("write answer late");
  property p_b_block; s_axi_bvalid |-> !s_axi_awready && !s_axi_wready; endproperty
  a_b_block: assert property (p_b_block) else $error("write taken during answer");
  property p_b_done; s_axi_bvalid && s_axi_bready |=> !s_axi_bvalid; endproperty
  a_b_done: assert property (p_b_done) else $error("write answer stuck");
  property p_rd_resp; s_axi_arvalid && s_axi_arready |=> s_axi_rvalid; endproperty
  a_rd_resp: assert property (p_rd_resp) else $error("read answer late");
  property p_r_block; s_axi_rvalid |-> !s_axi_arready; endproperty
  a_r_block: assert property (p_r_block) else $error("read taken during answer");
  property p_rd_upper; s_axi_rvalid |-> s_axi_rdata[31:8] == 24'h000000; endproperty
  a_rd_upper: assert property (p_rd_upper) else $error("upper read bits set");
  property p_swap_go; s_swap_go |=> overlap_active; endproperty
  a_swap_go: assert property (p_swap_go) else $error("swap did not start");
  property p_swap_off; swap_start && !cal_enable && !overlap_active |=> !overlap_active; endproperty
  a_swap_off: assert property (p_swap_off) else $error("swap without enable");
  property p_ovl_len;
    $fell(overlap_active) |-> ovl_q == 7'(trim_regs_pkg::OVERLAP_BASE
      + trim_regs_pkg::OVERLAP_SCALE * trims.overlap_delay);
  endproperty
  a_ovl_len: assert property (p_ovl_len) else $error("overlap length wrong");
  property p_ovl_dly;
    overlap_active && $past(overlap_active) |=> !overlap_active || $stable(trims.overlap_delay);
  endproperty
  a_ovl_dly: assert property (p_ovl_dly) else $error("delay moved in overlap");
endmodule

bind trim_swap_regs trim_swap_regs_monitor u_mon (
  .ref_clk, .rst_n, .conv_clk_en, .swap_start, .overlap_active, .cal_enable, .trims,
  .s_axi_awvalid, .s_axi_awready, .s_axi_wvalid, .s_axi_wready, .s_axi_bvalid,
  .s_axi_bready, .s_axi_arvalid, .s_axi_arready, .s_axi_rvalid, .s_axi_rdata
);
`default_nettype wire

// >>> tb/trim_and_swap_delay_regs_tb.sv
/*
  Self-checking bench for the trim and swap-delay register bank.
  Assumes the package, design and checker are compiled before it.
*/
`timescale 1ns/1ps
`default_nettype none
module trim_and_swap_delay_regs_tb;
  logic                     ref_clk, rst_n, fuse_valid, conv_clk_en, conv_hold, swap_start;
  logic                     overlap_active, cal_enable, s_axi_awvalid, s_axi_awready;
  logic                     s_axi_wvalid, s_axi_wready, s_axi_bvalid, s_axi_bready;
  logic                     s_axi_arvalid, s_axi_arready, s_axi_rvalid, s_axi_rready;
  logic [11:0]              s_axi_awaddr, s_axi_araddr;
  logic [31:0]              s_axi_wdata, s_axi_rdata, wd, rd;
  logic [3:0]               s_axi_wstrb;
  logic [1:0]               s_axi_bresp, s_axi_rresp, rs;
  logic [63:0]              rv;
  logic [7:0]               mdl [7];
  logic [9:0]               idx [7];
  trim_regs_pkg::trim_set_t fuse_trims, trims, ft;
  int                       seed, error_cnt, compares, cyc;

  trim_swap_regs u_dut (
    .ref_clk, .rst_n, .fuse_valid, .fuse_trims, .conv_clk_en, .swap_start, .trims,
    .overlap_active, .cal_enable, .s_axi_awvalid, .s_axi_awready, .s_axi_awaddr,
    .s_axi_wvalid, .s_axi_wready, .s_axi_wdata, .s_axi_wstrb, .s_axi_bvalid,
    .s_axi_bready, .s_axi_bresp, .s_axi_arvalid, .s_axi_arready, .s_axi_araddr,
    .s_axi_rvalid, .s_axi_rready, .s_axi_rdata, .s_axi_rresp
  );

  initial begin
    ref_clk = 1'b0;
    forever #12.5 ref_clk = ~ref_clk;
  end

  // Hang guard and converter pulses
  always @(posedge ref_clk) begin
    cyc++;
    conv_clk_en <= conv_hold || ($random(seed) % 2 != 0);
    if (cyc == 20000) begin
      error_cnt++;
      test_done;
    end
  end

  function automatic logic [11:0] ba(input logic [9:0] i);
    return {i, 2'b00};
  endfunction
  function automatic logic [7:0] rmask(input int k, input logic [7:0] v);
    return k == 1 ? v & trim_regs_pkg::BANDGAP_MASK : k == 6 ? v & trim_regs_pkg::DELAY_MASK : v;
  endfunction
  function automatic int ovl_len(input logic [7:0] d);
    return trim_regs_pkg::OVERLAP_BASE + trim_regs_pkg::OVERLAP_SCALE * d;
  endfunction

  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    compares++;
    if (got !== exp) begin
      error_cnt++;
      $display("[ERR] t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask

  task automatic axi_wr(input logic [11:0] a, input logic [31:0] d, output logic [1:0] r);
    @(posedge ref_clk);
    s_axi_awvalid <= 1'b1;
    s_axi_awaddr  <= a;
    s_axi_wvalid  <= 1'b1;
    s_axi_wdata   <= d;
    s_axi_bready  <= 1'b1;
    do begin
      @(posedge ref_clk);
      if (s_axi_awready) s_axi_awvalid <= 1'b0;
      if (s_axi_wready) s_axi_wvalid <= 1'b0;
    end while (s_axi_bvalid !== 1'b1);
    r = s_axi_bresp;
    s_axi_bready <= 1'b0;
  endtask

  task automatic axi_rd(input logic [11:0] a, output logic [31:0] d, output logic [1:0] r);
    @(posedge ref_clk);
    s_axi_arvalid <= 1'b1;
    s_axi_araddr  <= a;
    s_axi_rready  <= 1'b1;
    do begin
      @(posedge ref_clk);
      if (s_axi_arready) s_axi_arvalid <= 1'b0;
    end while (s_axi_rvalid !== 1'b1);
    d = s_axi_rdata;
    r = s_axi_rresp;
    s_axi_rready <= 1'b0;
  endtask

  task automatic rd_chk(input int k);
    axi_rd(ba(idx[k]), rd, rs);
    chk(rs, trim_regs_pkg::RESP_OKAY);
    chk(rd, {24'h0, mdl[k]});
  endtask

  task automatic chk_out;
    chk(trims.core_gain, mdl[0]);
    chk(trims.bandgap, mdl[1]);
    for (int c = 0; c < 4; c++) chk(trims.term[c], mdl[c+2]);
  endtask

  task automatic swap(input logic [7:0] d);
    int n;
    n = 0;
    axi_wr(ba(trim_regs_pkg::IDX_SWAP_OVERLAP), {24'h0, d}, rs);
    axi_wr(ba(trim_regs_pkg::IDX_SWAP_CTRL), 32'h1, rs);
    chk(cal_enable, 1'b1);
    conv_hold  <= 1'b1;
    swap_start <= 1'b1;
    @(posedge ref_clk);
    swap_start <= 1'b0;
    #1;
    while (overlap_active === 1'b1) begin
      n++;
      @(posedge ref_clk);
      #1;
    end
    conv_hold <= 1'b0;
    chk(n, ovl_len(d));
    chk(trims.overlap_delay, d);
    axi_wr(ba(trim_regs_pkg::IDX_SWAP_CTRL), 32'h0, rs);
  endtask

  task automatic test_done;
    $display("compares=%0d errors=%0d", compares, error_cnt);
    if (error_cnt == 0 && compares > 0) $display("== PASSED ==");
    else $display("== FAILED ==");
    $finish;
  endtask

  initial begin
    seed = 51121;
    {error_cnt, compares, cyc} = '0;
    {rst_n, fuse_valid, conv_hold, swap_start, s_axi_awvalid, s_axi_wvalid} = '0;
    {s_axi_bready, s_axi_arvalid, s_axi_rready, conv_clk_en} = '0;
    {s_axi_awaddr, s_axi_araddr, s_axi_wdata, fuse_trims} = '0;
    s_axi_wstrb = 4'hf;
    idx = '{trim_regs_pkg::IDX_CORE_GAIN_TRIM, trim_regs_pkg::IDX_BANDGAP_TRIM,
            trim_regs_pkg::IDX_TERM_TRIM_CH0, trim_regs_pkg::IDX_TERM_TRIM_CH1,
            trim_regs_pkg::IDX_TERM_TRIM_CH2, trim_regs_pkg::IDX_TERM_TRIM_CH3,
            trim_regs_pkg::IDX_SWAP_OVERLAP};
    repeat (5) @(posedge ref_clk);
    rst_n <= 1'b1;
    repeat (3) @(posedge ref_clk);
    mdl = '{default: 8'h00};
    mdl[6] = trim_regs_pkg::DELAY_RESET;
    for (int k = 0; k < 7; k++) rd_chk(k);
    chk(cal_enable, 1'b0);
    $display("test reset done");
    rv = {$random(seed), $random(seed)};
    ft = rv[48:0];
    fuse_trims <= ft;
    fuse_valid <= 1'b1;
    @(posedge ref_clk);
    fuse_valid <= 1'b0;
    mdl = '{ft.core_gain, {4'h0, ft.bandgap}, ft.term[0], ft.term[1], ft.term[2],
            ft.term[3], {3'h0, ft.overlap_delay}};
    for (int k = 0; k < 7; k++) rd_chk(k);
    chk_out;
    axi_rd(ba(trim_regs_pkg::IDX_SWAP_CTRL), rd, rs);
    chk(rd, 32'h4);
    $display("test fuse done");
    for (int p = 0; p < 4; p++) begin
      for (int k = 0; k < 7; k++) begin
        wd = p == 0 ? 32'hffffffff : p == 1 ? 32'h0 : $random(seed);
        axi_wr(ba(idx[k]), wd, rs);
        chk(rs, trim_regs_pkg::RESP_OKAY);
        mdl[k] = rmask(k, wd[7:0]);
        rd_chk(k);
        chk_out;
      end
    end
    $display("test rw done");
    axi_wr(12'h1ec, 32'hff, rs);
    chk(rs, trim_regs_pkg::RESP_SLVERR);
    axi_wr(12'h1e9, 32'hff, rs);
    chk(rs, trim_regs_pkg::RESP_SLVERR);
    axi_rd(12'h1ec, rd, rs);
    chk({rd, 2'b00, rs}, {32'h0, 2'b00, trim_regs_pkg::RESP_SLVERR});
    s_axi_wstrb <= 4'he;
    axi_wr(ba(idx[0]), {24'h0, ~mdl[0]}, rs);
    s_axi_wstrb <= 4'hf;
    chk(rs, trim_regs_pkg::RESP_OKAY);
    rd_chk(0);
    chk_out;
    $display("test unmapped done");
    foreach (mdl[k]) if (k < 4) swap(k == 0 ? 8'h00 : k == 1 ? 8'h07 : k == 2 ? 8'h1f : 8'h08);
    swap_start <= 1'b1;
    @(posedge ref_clk);
    swap_start <= 1'b0;
    @(posedge ref_clk);
    #1;
    chk(overlap_active, 1'b0);
    $display("test swap done");
    test_done;
  end
endmodule
`default_nettype wire
